// [core/iopa_core.sv]
`timescale 1ns/1ps
module iopa_core
  import iopa_pkg::*;
(
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                nrst,
  // Jumpers
  input  wire logic [UNIT_W-1:0]   unit_jumpers,
  input  wire logic [3:0]          mask_bit_sel,
  input  wire logic                flag_falling_sel,
  input  wire logic                pulse_mode,
  // Poll chain and interrupt
  input  wire logic                poll_chain_in,
  input  wire logic                int_request,
  input  wire logic                service_clear,
  output logic                     poll_chain_out,
  output logic                     shared_irq_line_n,
  output logic                     int_ack,
  output logic [UNIT_W-1:0]        unit_number_lines_o,
  output logic                     unit_number_lines_oe,
  // Direct command
  input  wire logic [UNIT_W-1:0]   unit_number_lines_i,
  input  wire logic                direct_command,
  output logic                     cmd_enable,
  // Data bus
  input  wire logic [DATA_W-1:0]   bus_data_lines_i,
  input  wire logic [DATA_W-1:0]   read_word,
  input  wire logic                direct_read_strobe,
  input  wire logic                program_read_strobe,
  input  wire logic                direct_status_strobe,
  input  wire logic                set_mask_command,
  input  wire logic                control_strobe,
  output logic [DATA_W-1:0]        bus_data_lines_o,
  output logic                     bus_data_lines_oe,
  output logic [DATA_W-1:0]        inbound_word,
  // Table fetch
  input  wire logic                table_fetch_request,
  input  wire logic                channel_acknowledge,
  input  wire logic                transfer_terminate,
  // Device transfer
  input  wire logic                write_strobe,
  input  wire logic                read_next_strobe,
  input  wire logic                device_flag,
  input  wire logic [CTRL_W-1:0]   ctrl_bits_in,
  input  wire logic                ctrl_load,
  output logic                     device_command,
  output logic [CTRL_W-1:0]        device_ctrl,
  output logic [1:0]               seq_count,
  output logic                     op_done
);
  import iopa_pkg::*;

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync;
  logic       rst_n;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ****************************************
  // Input synchronisers (poll and service clear cross in from the bus)
  // ****************************************
  logic [2:0] poll_s;
  logic [2:0] clr_s;
  logic       poll;
  logic       svc_clr;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      poll_s <= 3'h0;
      clr_s  <= 3'h0;
      poll   <= 1'b0;
      svc_clr <= 1'b0;
    end else begin
      poll_s <= {poll_s[1:0], poll_chain_in};
      clr_s  <= {clr_s[1:0], service_clear};
      if (poll_s[1] == poll_s[2]) begin
        poll <= poll_s[2];
      end
      if (clr_s[1] == clr_s[2]) begin
        svc_clr <= clr_s[2];
      end
    end
  end

  // ****************************************
  // Mask
  // ****************************************
  logic mask;
  logic master_clear;
  logic active;
  logic req_eff;
  logic latch_in;
  // Control word bit 0 or a service clear forces the master clear
  assign master_clear = svc_clr | (control_strobe & bus_data_lines_i[DATA_W-1-CLR_BIT]);
  assign req_eff      = int_request & ~active;
  assign latch_in     = mask & req_eff;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask <= MASK_RST;
    end else if (master_clear) begin
      mask <= 1'b1;
    end else if (set_mask_command) begin
      mask <= bus_data_lines_i[mask_bit_sel];
    end
  end

  // ****************************************
  // Poll latch and active flag
  // ****************************************
  logic                        latch;
  logic [POLL_DELAY_CYC-1:0]   poll_dly;
  logic                        poll_late;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch <= 1'b0;
    end else if (poll) begin
      latch <= latch_in;
    end
  end

  // Clocked stand-in for the short gate delay; also lets the latch settle first
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      poll_dly <= '0;
    end else begin
      poll_dly <= POLL_DELAY_CYC'({poll_dly, poll});
    end
  end
  assign poll_late = poll_dly[POLL_DELAY_CYC-1];

  // Set wins over service clear so a poll racing the clear is not lost
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      active <= 1'b0;
    end else if (poll_late && latch) begin
      active <= 1'b1;
    end else if (svc_clr) begin
      active <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      poll_chain_out       <= 1'b0;
      shared_irq_line_n    <= 1'b1;
      int_ack              <= 1'b0;
      unit_number_lines_o  <= '0;
      unit_number_lines_oe <= 1'b0;
    end else begin
      poll_chain_out       <= poll & ~latch_in & ~latch;
      shared_irq_line_n    <= ~latch_in;
      int_ack              <= active | (poll_late & latch);
      unit_number_lines_oe <= poll_late & latch;
      unit_number_lines_o  <= unit_jumpers;
    end
  end

  // ****************************************
  // Direct command compare
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_enable <= 1'b0;
    end else begin
      cmd_enable <= direct_command & ~latch_in & (unit_number_lines_i == unit_jumpers);
    end
  end

  // ****************************************
  // Data gates
  // ****************************************
  logic table_en;
  logic rd_en;
  assign table_en = table_fetch_request | (channel_acknowledge & transfer_terminate);
  assign rd_en    = direct_read_strobe | program_read_strobe | direct_status_strobe;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_data_lines_o  <= '0;
      bus_data_lines_oe <= 1'b0;
      inbound_word      <= '0;
    end else begin
      inbound_word      <= bus_data_lines_i;
      bus_data_lines_oe <= rd_en | table_en;
      if (table_en) begin
        // Bits 6..13 counted from the top sit two places up: the number times four
        bus_data_lines_o <= DATA_W'(unit_jumpers) << (DATA_W - TABLE_LSB - UNIT_W);
      end else if (rd_en) begin
        bus_data_lines_o <= read_word;
      end else begin
        bus_data_lines_o <= '0;
      end
    end
  end

  // ****************************************
  // Device control bits
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      device_ctrl <= '0;
    end else if (master_clear) begin
      device_ctrl <= '0;
    end else if (ctrl_load) begin
      device_ctrl <= ctrl_bits_in;
    end
  end

  // ****************************************
  // Sequence counter
  // ****************************************
  logic        flag_q;
  iopa_count_e cnt;
  logic        q0;
  logic        wr_arm;
  logic        rd_arm;
  logic        qual;
  logic        done;

  iopa_edge u_edge (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .flag_pin   (device_flag),
    .use_falling(flag_falling_sel),
    .edge_pulse (flag_q)
  );

  // Device end always lets the count run through to 0
  always_comb begin
    case (cnt)
      IOPA_C0: qual = q0;
      IOPA_C1: qual = flag_q | transfer_terminate;
      IOPA_C2: qual = pulse_mode | flag_q | transfer_terminate;
      IOPA_C3: qual = 1'b1;
      default: qual = 1'b0;
    endcase
  end
  assign done = (cnt == IOPA_C3) & qual;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q0 <= 1'b0;
    end else if (write_strobe || read_next_strobe) begin
      q0 <= 1'b1;
    end else if (cnt == IOPA_C1) begin
      q0 <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_arm <= 1'b0;
      rd_arm <= 1'b0;
    end else begin
      if (write_strobe) begin
        wr_arm <= 1'b1;
      end else if (done || master_clear) begin
        wr_arm <= 1'b0;
      end
      if (read_next_strobe) begin
        rd_arm <= 1'b1;
      end else if (done || master_clear) begin
        rd_arm <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= iopa_count_e'(CNT_RST);
    end else if (master_clear) begin
      cnt <= IOPA_C0;
    end else if (qual) begin
      case (cnt)
        IOPA_C0: cnt <= IOPA_C1;
        IOPA_C1: cnt <= IOPA_C2;
        IOPA_C2: cnt <= IOPA_C3;
        IOPA_C3: cnt <= IOPA_C0;
        default: cnt <= IOPA_C0;
      endcase
    end
  end

  // Response mode drops the command on the flag edge; pulse mode holds it for count 1
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      device_command <= 1'b0;
      seq_count      <= 2'h0;
      op_done        <= 1'b0;
    end else begin
      device_command <= (cnt == IOPA_C1) & (wr_arm | rd_arm) & ~(flag_q & ~pulse_mode);
      seq_count      <= cnt;
      op_done        <= done;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_poll_rise;
    $rose(poll) ##0 latch_in;
  endsequence
  sequence s_ack_up;
    ##[1:8] int_ack;
  endsequence

  a_irq_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 (shared_irq_line_n == !$past(latch_in))) else $error("irq line mismatch");
  a_poll_block: assert property (@(posedge core_clk) disable iff (!rst_n)
    latch |=> !poll_chain_out) else $error("poll passed while latched");
  a_ack_rise: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_poll_rise |-> s_ack_up) else $error("no acknowledge after poll");
  a_ack_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    (active && !svc_clr && !poll_late) |=> active) else $error("active dropped early");
  a_mask_clr: assert property (@(posedge core_clk) disable iff (!rst_n)
    master_clear |=> mask) else $error("mask not set by clear");
  a_data_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    bus_data_lines_oe |-> $past(rd_en | table_en)) else $error("data driven without strobe");
  a_table_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
    table_en |=> bus_data_lines_o == (DATA_W'($past(unit_jumpers)) << (DATA_W - TABLE_LSB - UNIT_W)))
    else $error("table address bad");
  a_cmd_match: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_enable |-> $past(unit_number_lines_i == unit_jumpers)) else $error("command without match");
  a_cmd_count: assert property (@(posedge core_clk) disable iff (!rst_n)
    device_command |-> $past(cnt == IOPA_C1)) else $error("command outside count 1");
  a_seq_start: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cnt == IOPA_C0 && q0 && !master_clear) |=> cnt == IOPA_C1) else $error("counter did not start");
endmodule : iopa_core

// [core/iopa_pkg.sv]
package iopa_pkg;
  localparam int DATA_W = 16;
  localparam int UNIT_W = 8;
  localparam int CTRL_W = 5;
  // Bus bit numbers count down from the most significant line, as the bus labels them
  // Top bit of the unit number inside the table address word (number times four)
  localparam int TABLE_LSB = 6;
  // Control word bit that forces a master clear, counted from the top
  localparam int CLR_BIT = 0;
  // Short delay from poll entry to number drive
  localparam int POLL_DELAY_NS = 10;
  localparam int CLK_PERIOD_NS = 5;
  localparam int POLL_DELAY_CYC = (POLL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic MASK_RST = 1'b1;
  localparam logic [1:0] CNT_RST = 2'h0;

  typedef enum logic [1:0] {
    IOPA_C0 = 2'b00,
    IOPA_C1 = 2'b01,
    IOPA_C2 = 2'b11,
    IOPA_C3 = 2'b10
  } iopa_count_e;
endpackage : iopa_pkg

// [core/iopa_edge.sv]
`timescale 1ns/1ps
// Three-stage synchroniser with edge select; one pulse per accepted edge
module iopa_edge (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Asynchronous flag and selection
  input  wire logic flag_pin,
  input  wire logic use_falling,
  // Qualifier pulse
  output logic      edge_pulse
);
  logic [2:0] sync;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync <= 3'h0;
    end else begin
      sync <= {sync[1:0], flag_pin};
    end
  end

  // Stage 0 feeds stage 1 only; compare the settled stages
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_pulse <= 1'b0;
    end else begin
      edge_pulse <= use_falling ? (sync[2] & ~sync[1]) : (~sync[2] & sync[1]);
    end
  end

  a_one_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    edge_pulse |=> !edge_pulse) else $error("flag edge gave two pulses");
endmodule : iopa_edge

// [test/iopa_dev_model.sv]
`timescale 1ns/1ps
// ****
// External device: answers each command with flag pulses
// ****
module iopa_dev_model (
  // Clock
  input  wire logic       core_clk,
  // Handshake
  input  wire logic       device_command,
  input  wire logic [7:0] flag_delay,
  input  wire logic [1:0] flag_pulses,
  output logic            device_flag
);
  int k;
  // Flag is a driven line, so it idles low between answers
  initial begin
    device_flag = 1'b0;
    forever begin
      @(posedge device_command);
      for (k = 0; k < flag_pulses; k++) begin
        repeat (flag_delay) @(posedge core_clk);
        #1 device_flag = 1'b1;
        repeat (4) @(posedge core_clk);
        #1 device_flag = 1'b0;
      end
    end
  end
endmodule : iopa_dev_model

// [test/io_interrupt_poll_and_address_bench.sv]
`timescale 1ns/1ps
module io_interrupt_poll_and_address_bench;
  import iopa_pkg::*;
  // ****
  // Signals
  // ****
  logic core_clk = 1'b0, nrst = 1'b0;
  logic [7:0] unit_jumpers, unit_number_lines_i, unit_number_lines_o, fdel;
  logic [3:0] mask_bit_sel;
  logic [4:0] ctrl_bits_in, device_ctrl;
  logic [15:0] bus_data_lines_i, read_word, bus_data_lines_o, inbound_word;
  logic [1:0] seq_count, fpul;
  logic flag_falling_sel, pulse_mode, poll_chain_in, int_request, service_clear;
  logic poll_chain_out, shared_irq_line_n, int_ack, unit_number_lines_oe;
  logic direct_command, cmd_enable, direct_read_strobe, program_read_strobe;
  logic direct_status_strobe, set_mask_command, control_strobe, bus_data_lines_oe;
  logic table_fetch_request, channel_acknowledge, transfer_terminate;
  logic write_strobe, read_next_strobe, device_flag, ctrl_load, device_command, op_done;
  int error_cnt = 0, tests_run = 0, i, t, d, r;
  logic [31:0] seed = 32'hF0D2AB48;

  always #2.5 core_clk = ~core_clk;

  iopa_core i_dut (.core_clk, .nrst, .unit_jumpers, .mask_bit_sel, .flag_falling_sel,
    .pulse_mode, .poll_chain_in, .int_request, .service_clear, .poll_chain_out,
    .shared_irq_line_n, .int_ack, .unit_number_lines_o, .unit_number_lines_oe,
    .unit_number_lines_i, .direct_command, .cmd_enable, .bus_data_lines_i, .read_word,
    .direct_read_strobe, .program_read_strobe, .direct_status_strobe, .set_mask_command,
    .control_strobe, .bus_data_lines_o, .bus_data_lines_oe, .inbound_word,
    .table_fetch_request, .channel_acknowledge, .transfer_terminate, .write_strobe,
    .read_next_strobe, .device_flag, .ctrl_bits_in, .ctrl_load, .device_command,
    .device_ctrl, .seq_count, .op_done);

  iopa_dev_model i_dev (.core_clk, .device_command, .flag_delay(fdel),
    .flag_pulses(fpul), .device_flag);

  // ****
  // Helpers
  // ****
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic test_done();
    $display("Checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic probe(input int k);
    case (k)
      0: return int_ack;
      1: return device_command;
      2: return op_done;
      3: return poll_chain_out;
      default: return ~shared_irq_line_n;
    endcase
  endfunction : probe

  // Bounded wait so a stuck handshake ends the run instead of hanging it
  task automatic wait_for(input int k);
    int n;
    n = 0;
    while (probe(k) !== 1'b1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 300) begin
      error_cnt++;
      $display("[ERR] %0t wait expired", $time);
      test_done();
    end
  endtask : wait_for

  task automatic step(input int n);
    repeat (n) @(negedge core_clk);
  endtask : step

  // ****
  // Main sequence
  // ****
  initial begin
    {mask_bit_sel, flag_falling_sel, poll_chain_in, int_request, service_clear} = '0;
    {unit_number_lines_i, direct_command, direct_read_strobe, program_read_strobe} = '0;
    {direct_status_strobe, set_mask_command, control_strobe, table_fetch_request} = '0;
    {channel_acknowledge, transfer_terminate, write_strobe, read_next_strobe} = '0;
    {ctrl_bits_in, ctrl_load, bus_data_lines_i, read_word} = '0;
    pulse_mode = 1'b1;
    fdel = 8'h02;
    fpul = 2'h1;
    unit_jumpers = rnd();
    step(1);
    check({shared_irq_line_n, bus_data_lines_oe, int_ack, seq_count}, 16'h0010);
    step(1);
    nrst = 1'b1;
    step(4);
    // Outbound gates open on each read or status strobe and stay shut with none; inbound always open
    for (i = 0; i < 12; i++) begin
      d = rnd();
      r = rnd();
      bus_data_lines_i = d;
      read_word = r;
      {direct_read_strobe, program_read_strobe, direct_status_strobe} =
        (i % 4 == 0) ? 3'h0 : 3'h1 << (i % 4 - 1);
      step(1);
      check(inbound_word, d[15:0]);
      check(bus_data_lines_oe, (i % 4) != 0);
      if (i % 4 != 0) check(bus_data_lines_o, r[15:0]);
    end
    {direct_read_strobe, program_read_strobe, direct_status_strobe} = '0;
    // Table address: fetch request, ack with terminate, ack alone
    for (i = 0; i < 3; i++) begin
      table_fetch_request = (i == 0);
      channel_acknowledge = (i != 0);
      transfer_terminate = (i == 1);
      step(1);
      check(bus_data_lines_oe, i != 2);
      if (i != 2) check(bus_data_lines_o, unit_jumpers * 4);
    end
    {table_fetch_request, channel_acknowledge, transfer_terminate} = '0;
    // Number compare: exact match, then each single-bit miss
    direct_command = 1'b1;
    for (i = 0; i < 9; i++) begin
      unit_number_lines_i = unit_jumpers ^ 8'((9'h001 << i) >> 1);
      step(2);
      check(cmd_enable, i == 0);
    end
    direct_command = 1'b0;
    // Mask cleared by a zero selected bit, request line must stay idle
    mask_bit_sel = 4'h3;
    bus_data_lines_i = 16'hFFF7;
    set_mask_command = 1'b1;
    step(1);
    set_mask_command = 1'b0;
    int_request = 1'b1;
    step(3);
    check(shared_irq_line_n, 1'b1);
    bus_data_lines_i = 16'h0008;
    set_mask_command = 1'b1;
    step(1);
    set_mask_command = 1'b0;
    wait_for(4);
    // A pending request refuses direct commands even on a full match
    direct_command = 1'b1;
    unit_number_lines_i = unit_jumpers;
    step(2);
    check(cmd_enable, 1'b0);
    direct_command = 1'b0;
    // Poll: ack, number on lines, chain blocked
    poll_chain_in = 1'b1;
    wait_for(0);
    check(unit_number_lines_oe, 1'b1);
    check(unit_number_lines_o, unit_jumpers);
    check(poll_chain_out, 1'b0);
    poll_chain_in = 1'b0;
    step(8);
    check({int_ack, shared_irq_line_n}, 2'h3);
    int_request = 1'b0;
    service_clear = 1'b1;
    step(8);
    service_clear = 1'b0;
    step(8);
    check(int_ack, 1'b0);
    poll_chain_in = 1'b1;
    wait_for(3);
    poll_chain_in = 1'b0;
    // Master clear from control bit 0 sets the mask again
    bus_data_lines_i = 16'h0000;
    set_mask_command = 1'b1;
    step(1);
    set_mask_command = 1'b0;
    bus_data_lines_i = 16'h8000;
    control_strobe = 1'b1;
    step(1);
    control_strobe = 1'b0;
    step(2);
    int_request = 1'b1;
    wait_for(4);
    int_request = 1'b0;
    service_clear = 1'b1;
    step(8);
    service_clear = 1'b0;
    step(8);
    ctrl_bits_in = rnd();
    ctrl_load = 1'b1;
    step(1);
    ctrl_load = 1'b0;
    step(1);
    check(device_ctrl, ctrl_bits_in);
    // Transfers: pulse mode with rising edge, response mode with falling edge
    for (t = 0; t < 2; t++) begin
      pulse_mode = (t == 0);
      flag_falling_sel = (t == 1);
      fpul = t + 1;
      fdel = (t == 1) ? 8'h14 : 8'h02;
      if (t == 0) write_strobe = 1'b1;
      else read_next_strobe = 1'b1;
      step(1);
      {write_strobe, read_next_strobe} = '0;
      wait_for(1);
      check(seq_count, IOPA_C1);
      wait_for(2);
      // The count output lags the done pulse by one cycle
      step(1);
      check(seq_count, CNT_RST);
      check(op_done, 1'b0);
      step(1);
      check(device_command, 1'b0);
    end
    test_done();
  end
endmodule : io_interrupt_poll_and_address_bench
